// >>> dsrp_top.sv
// serial register port: 3/4-wire framing, register types, autosync group
`timescale 1ns/1ps
`default_nettype none

module dsrp_top (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_IN,
  // serial link pins (inputs asynchronous, outputs registered on REF_CLK_IN)
  input  wire logic        SERIAL_CLOCK_IN,
  input  wire logic        SERIAL_FRAME_ENABLE_N_IN,
  input  wire logic        SERIAL_DATA_IN,
  output logic             SERIAL_DATA_OUT,
  output logic             SERIAL_DATA_OE_OUT,
  output logic             SERIAL_READ_OUT_PIN_OUT,
  output logic             SERIAL_READ_OUT_PIN_OE_OUT,
  // internal sources
  input  wire logic [15:0] STATUS_IN,
  input  wire logic [15:0] EVENT_IN,
  input  wire logic [7:0]  SENSOR_IN,
  // register contents toward the device
  output logic [63:0]      CONFIG_WORDS_OUT,
  output logic [31:0]      AUTOSYNC_WORDS_OUT,
  output logic             AUTOSYNC_PULSE_OUT,
  output logic [15:0]      EVENT_FLAGS_OUT,
  output logic             FOUR_WIRE_SELECT_OUT
);

  localparam int SYNC_W = 43;

  // ===========================================================================
  // input synchronisers
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic              sclk_prev;
  logic [SYNC_W-1:0] next_sync_a;
  logic [SYNC_W-1:0] next_sync_b;
  logic              next_sclk_prev;

  always_comb
  begin
    next_sync_a    = {SENSOR_IN, STATUS_IN, EVENT_IN, SERIAL_DATA_IN,
                      SERIAL_FRAME_ENABLE_N_IN, SERIAL_CLOCK_IN};
    next_sync_b    = sync_a;
    next_sclk_prev = sync_b[0];
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      sync_a    <= {{(SYNC_W-2){1'b0}}, 2'b10};
      sync_b    <= {{(SYNC_W-2){1'b0}}, 2'b10};
      sclk_prev <= 1'b0;
    end
    else
    begin
      sync_a    <= next_sync_a;
      sync_b    <= next_sync_b;
      sclk_prev <= next_sclk_prev;
    end
  end

  logic        sclk;
  logic        frame_n;
  logic        sdi;
  logic [15:0] ev;
  logic [15:0] st;
  logic [7:0]  sen;
  logic        rise;
  logic        fall;

  assign sclk    = sync_b[0];
  assign frame_n = sync_b[1];
  assign sdi     = sync_b[2];
  assign ev      = sync_b[18:3];
  assign st      = sync_b[34:19];
  assign sen     = sync_b[42:35];
  assign rise    = sclk & ~sclk_prev;
  assign fall    = ~sclk & sclk_prev;

  // ===========================================================================
  // frame engine
  dsrp_pkg::dsrp_state_t state;
  dsrp_pkg::dsrp_state_t next_state;
  logic [4:0]  cnt;
  logic [15:0] shift;
  logic        rd;
  logic [6:0]  addr;
  logic [15:0] rd_shift;
  logic        sdio_o;
  logic        sdio_oe;
  logic        sdo_oe;
  logic [4:0]  next_cnt;
  logic [15:0] next_shift;
  logic        next_rd;
  logic [6:0]  next_addr;
  logic [15:0] next_rd_shift;
  logic        next_sdio_o;
  logic        next_sdio_oe;
  logic        next_sdo_oe;
  logic        commit;
  logic [15:0] wdata;
  logic [15:0] rd_word;
  logic [15:0] mem_rdata;
  logic [127:0] mem_words;
  logic        four_wire;
  logic [7:0]  live_low;

  assign four_wire = mem_words[dsrp_pkg::FOUR_WIRE_BIT];
  assign wdata     = {shift[14:0], sdi};
  assign commit    = (state == dsrp_pkg::ST_DATA) && rise && !rd
                     && (cnt == dsrp_pkg::DATA_LAST);

  // read mux: status gated by its decode, live bits pass straight through
  always_comb
  begin
    rd_word = dsrp_pkg::WORD_ZERO;
    if (addr < dsrp_pkg::ADDR_NORMAL_END)
      rd_word = mem_rdata;
    else if (addr == dsrp_pkg::ADDR_EVENTS)
      rd_word = EVENT_FLAGS_OUT;
    else if (addr == dsrp_pkg::ADDR_LIVE)
      rd_word = {sen, live_low};
    rd_word = rd_word | (st & {16{addr == dsrp_pkg::ADDR_STATUS}});
  end

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_shift    = shift;
    next_rd       = rd;
    next_addr     = addr;
    next_rd_shift = rd_shift;
    next_sdio_o   = sdio_o;
    next_sdio_oe  = sdio_oe;
    next_sdo_oe   = sdo_oe;
    if (frame_n)
    begin
      // frame end releases both pins whatever the phase
      next_state   = dsrp_pkg::ST_IDLE;
      next_cnt     = dsrp_pkg::CNT_ZERO;
      next_sdio_o  = 1'b0;
      next_sdio_oe = 1'b0;
      next_sdo_oe  = 1'b0;
    end
    else
    begin
      case (state)
        dsrp_pkg::ST_IDLE:
        begin
          next_state = dsrp_pkg::ST_INSTR;
          next_cnt   = dsrp_pkg::CNT_ZERO;
        end
        dsrp_pkg::ST_INSTR:
        begin
          if (rise)
          begin
            next_shift = wdata;
            next_cnt   = cnt + dsrp_pkg::CNT_ONE;
            if (cnt == dsrp_pkg::INSTR_LAST)
            begin
              next_rd    = shift[dsrp_pkg::RW_POS];
              next_addr  = wdata[6:0];
              next_cnt   = dsrp_pkg::CNT_ZERO;
              next_state = dsrp_pkg::ST_DATA;
            end
          end
        end
        dsrp_pkg::ST_DATA:
        begin
          if (rise)
          begin
            next_shift = wdata;
            next_cnt   = cnt + dsrp_pkg::CNT_ONE;
            if (cnt == dsrp_pkg::DATA_LAST)
              next_state = dsrp_pkg::ST_TAIL;
          end
          else if (fall && rd)
          begin
            if (cnt == dsrp_pkg::CNT_ZERO)
            begin
              next_sdio_o   = rd_word[15];
              next_rd_shift = {rd_word[14:0], 1'b0};
              next_sdio_oe  = 1'b1;
              next_sdo_oe   = four_wire;
            end
            else
            begin
              next_sdio_o   = rd_shift[15];
              next_rd_shift = {rd_shift[14:0], 1'b0};
            end
          end
        end
        dsrp_pkg::ST_TAIL:
        begin
          // bits past the word are ignored; pins held low until frame end
          if (fall)
            next_sdio_o = 1'b0;
        end
        default:
        begin
          next_state = dsrp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      state    <= dsrp_pkg::ST_IDLE;
      cnt      <= dsrp_pkg::CNT_ZERO;
      shift    <= dsrp_pkg::WORD_ZERO;
      rd       <= 1'b0;
      addr     <= dsrp_pkg::ADDR_FIRST_CONFIGURATION_REGISTER;
      rd_shift <= dsrp_pkg::WORD_ZERO;
      sdio_o   <= 1'b0;
      sdio_oe  <= 1'b0;
      sdo_oe   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      shift    <= next_shift;
      rd       <= next_rd;
      addr     <= next_addr;
      rd_shift <= next_rd_shift;
      sdio_o   <= next_sdio_o;
      sdio_oe  <= next_sdio_oe;
      sdo_oe   <= next_sdo_oe;
    end
  end

  assign SERIAL_DATA_OUT            = sdio_o;
  assign SERIAL_DATA_OE_OUT         = sdio_oe;
  assign SERIAL_READ_OUT_PIN_OUT    = sdio_o;
  assign SERIAL_READ_OUT_PIN_OE_OUT = sdo_oe;

  // ===========================================================================
  // normal registers
  dsrp_regmem #(
    .WIDTH (dsrp_pkg::WORD_W),
    .DEPTH (dsrp_pkg::NORMAL_DEPTH),
    .AW    (dsrp_pkg::NORMAL_AW)
  ) u_mem (
    .clk_in    (REF_CLK_IN),
    .rst_in    (RESET_IN),
    .we_in     (commit && (addr < dsrp_pkg::ADDR_NORMAL_END)),
    .waddr_in  (addr[dsrp_pkg::NORMAL_AW-1:0]),
    .wdata_in  (wdata),
    .raddr_in  (addr[dsrp_pkg::NORMAL_AW-1:0]),
    .rdata_out (mem_rdata),
    .words_out (mem_words)
  );

  // ===========================================================================
  // event flags, live register, autosync group
  logic        sync_req;
  logic [15:0] clr_mask;
  logic [15:0] next_flags;
  logic [7:0]  next_live_low;
  logic        next_sync_req;
  logic        next_pulse;
  logic [31:0] next_group;
  logic        next_four_wire;

  assign clr_mask = (commit && addr == dsrp_pkg::ADDR_EVENTS) ? ~wdata : dsrp_pkg::WORD_ZERO;

  always_comb
  begin
    // a new event beats a clear in the same cycle
    next_flags     = (EVENT_FLAGS_OUT & ~clr_mask) | ev;
    next_live_low  = (commit && addr == dsrp_pkg::ADDR_LIVE) ? wdata[7:0] : live_low;
    next_sync_req  = commit && (addr == dsrp_pkg::ADDR_GROUP_HI);
    next_pulse     = sync_req;
    // group words move only together, one cycle after the last write lands
    next_group     = sync_req ? mem_words[2*dsrp_pkg::WORD_W*2 +: 32] : AUTOSYNC_WORDS_OUT;
    next_four_wire = four_wire;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      EVENT_FLAGS_OUT      <= dsrp_pkg::WORD_ZERO;
      live_low             <= dsrp_pkg::BYTE_ZERO;
      sync_req             <= 1'b0;
      AUTOSYNC_PULSE_OUT   <= 1'b0;
      AUTOSYNC_WORDS_OUT   <= '0;
      FOUR_WIRE_SELECT_OUT <= 1'b0;
    end
    else
    begin
      EVENT_FLAGS_OUT      <= next_flags;
      live_low             <= next_live_low;
      sync_req             <= next_sync_req;
      AUTOSYNC_PULSE_OUT   <= next_pulse;
      AUTOSYNC_WORDS_OUT   <= next_group;
      FOUR_WIRE_SELECT_OUT <= next_four_wire;
    end
  end

  assign CONFIG_WORDS_OUT = mem_words[63:0];

  // ===========================================================================
  // assertions
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence seq_instr_done;
    (state == dsrp_pkg::ST_INSTR) && rise && !frame_n && (cnt == dsrp_pkg::INSTR_LAST);
  endsequence

  sequence seq_group_commit;
    commit && !frame_n && (addr == dsrp_pkg::ADDR_GROUP_HI);
  endsequence

  AST_FRAME_RELEASE: assert property (frame_n |=> ##1 (!sdio_oe && !sdo_oe))
    else $error("pins still driven after frame end");
  AST_THREE_WIRE_SDO_OFF: assert property ($rose(sdio_oe) && !$past(four_wire) |-> !sdo_oe)
    else $error("read pin driven in three-wire mode");
  AST_FOUR_WIRE_BOTH: assert property ($rose(sdio_oe) |-> (sdo_oe == $past(four_wire)))
    else $error("four-wire read not on both pins");
  AST_WRITE_NO_DRIVE: assert property ((state == dsrp_pkg::ST_DATA) && !rd |-> !sdio_oe)
    else $error("data pin driven during write");
  AST_OUT_ON_FALL: assert property ($changed(sdio_o) && !$past(frame_n) |-> $past(fall))
    else $error("read bit changed off a falling edge");
  AST_SAMPLE_ON_RISE: assert property ($changed(shift) |-> $past(rise))
    else $error("input bit taken off a rising edge");
  AST_INSTR_DECODE: assert property (seq_instr_done |=> (state == dsrp_pkg::ST_DATA)
                                     && (rd == $past(shift[dsrp_pkg::RW_POS])))
    else $error("instruction byte not decoded");
  AST_AUTOSYNC: assert property (seq_group_commit |-> ##2 AUTOSYNC_PULSE_OUT
                                 ##1 !AUTOSYNC_PULSE_OUT)
    else $error("autosync pulse missing or long");
  AST_NORMAL_WORD: assert property (commit && addr == dsrp_pkg::ADDR_FIRST_CONFIGURATION_REGISTER
                                    |=> mem_words[15:0] == $past(wdata))
    else $error("normal word not taken whole");
  AST_FLAG_HOLD: assert property ((($past(EVENT_FLAGS_OUT) & ~$past(clr_mask))
                                   & ~EVENT_FLAGS_OUT) == dsrp_pkg::WORD_ZERO)
    else $error("event flag dropped without clear");
  AST_FLAG_SET: assert property ((EVENT_FLAGS_OUT & $past(ev)) == $past(ev))
    else $error("event not latched");
  AST_TAIL_LOW: assert property ((state == dsrp_pkg::ST_TAIL) && fall && !frame_n
                                 |=> !sdio_o)
    else $error("data not low after last bit");

endmodule : dsrp_top

`default_nettype wire

// >>> dsrp_pkg_mem.sv
// package of serial register port constants, plus the normal register memory
// =============================================================================
`timescale 1ns/1ps
`default_nettype none

package dsrp_pkg;
  localparam int             WORD_W         = 16;
  localparam int             ADDR_W         = 7;
  localparam int             NORMAL_DEPTH   = 8;
  localparam int             NORMAL_AW      = 3;
  localparam logic [4:0]     INSTR_LAST     = 5'h07;
  localparam logic [4:0]     DATA_LAST      = 5'h0F;
  localparam logic [4:0]     CNT_ZERO       = 5'h00;
  localparam logic [4:0]     CNT_ONE        = 5'h01;
  localparam int             RW_POS         = 6;
  localparam int             FOUR_WIRE_BIT  = 9;
  localparam logic [15:0]    CFG0_RESET     = 16'h44FC;
  localparam logic [15:0]    WORD_ZERO      = 16'h0000;
  localparam logic [7:0]     BYTE_ZERO      = 8'h00;
  localparam logic [6:0]     ADDR_FIRST_CONFIGURATION_REGISTER   = 7'h00;
  localparam logic [6:0]     ADDR_GROUP_LO  = 7'h04;
  localparam logic [6:0]     ADDR_GROUP_HI  = 7'h05;
  localparam logic [6:0]     ADDR_NORMAL_END = 7'h08;
  localparam logic [6:0]     ADDR_STATUS    = 7'h08;
  localparam logic [6:0]     ADDR_EVENTS    = 7'h09;
  localparam logic [6:0]     ADDR_LIVE      = 7'h0A;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_TAIL  = 4'b1000
  } dsrp_state_t;
endpackage : dsrp_pkg

// =============================================================================
// normal registers: one flop word per entry, registered read port
module dsrp_regmem #(
  parameter int WIDTH = dsrp_pkg::WORD_W,
  parameter int DEPTH = dsrp_pkg::NORMAL_DEPTH,
  parameter int AW    = dsrp_pkg::NORMAL_AW
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // write port
  input  wire logic                   we_in,
  input  wire logic [AW-1:0]          waddr_in,
  input  wire logic [WIDTH-1:0]       wdata_in,
  // read port
  input  wire logic [AW-1:0]          raddr_in,
  output logic      [WIDTH-1:0]       rdata_out,
  output logic      [DEPTH*WIDTH-1:0] words_out
);
  logic [WIDTH-1:0] next_rdata;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_word
      logic [WIDTH-1:0] word;
      logic [WIDTH-1:0] next_word;
      always_comb
      begin
        // all sixteen bits land in the same edge
        next_word = (we_in && waddr_in == AW'(i)) ? wdata_in : word;
      end
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          word <= (i == 0) ? dsrp_pkg::CFG0_RESET : dsrp_pkg::WORD_ZERO;
        else
          word <= next_word;
      end
      assign words_out[i*WIDTH +: WIDTH] = word;
    end
  endgenerate

  always_comb
  begin
    next_rdata = words_out[raddr_in*WIDTH +: WIDTH];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= dsrp_pkg::WORD_ZERO;
    else
      rdata_out <= next_rdata;
  end
endmodule : dsrp_regmem

`default_nettype wire

// >>> dsrp_host_model.sv
// serial host model: drives clock, frame enable and data-in of the register port
`timescale 1ns/1ps
`default_nettype none

module dsrp_host_model #(
  parameter int HALF_LO = 13,
  parameter int HALF_HI = 12
) (
  // clock
  input  wire logic clk_in,
  // link toward the port
  output logic      ser_clk_out,
  output logic      frame_n_out,
  output logic      din_out,
  // read-back views
  input  wire logic wire_in,
  input  wire logic data_oe_in,
  input  wire logic pin_in,
  input  wire logic pin_oe_in
);
  logic [15:0] rd_wire;
  logic [15:0] rd_pin;
  logic [15:0] rd_late;
  logic [3:0]  tail;
  logic [1:0]  idle;

  initial
  begin
    ser_clk_out = 1'b0;
    frame_n_out = 1'b1;
    din_out     = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_cyc

  // nbits below 24 ends the frame early; lead stretches the frame start
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                      input int nbits, input int lead);
    logic [23:0] word;
    word = {rd, addr, wdata};
    frame_n_out = 1'b0;
    wait_cyc(lead);
    for (int i = 23; i >= 24 - nbits; i--)
    begin
      if (rd && i == 15)
        din_out = ~din_out;  // flipped: a port that fails to drive leaves the opposite level on the shared pin
      else if (!rd || i > 15)
        din_out = word[i];
      wait_cyc(HALF_LO);
      if (i < 16)
      begin
        rd_wire[i] = wire_in;
        rd_pin[i]  = pin_oe_in ? pin_in : 1'bz;
      end
      ser_clk_out = 1'b1;
      wait_cyc(HALF_HI);
      if (i < 16)
        rd_late[i] = wire_in;
      ser_clk_out = 1'b0;
    end
    wait_cyc(6);
    tail = {data_oe_in, wire_in, pin_oe_in, pin_in};
    frame_n_out = 1'b1;
    wait_cyc(6);
    idle = {data_oe_in, pin_oe_in};
  endtask : xfer
endmodule : dsrp_host_model

`default_nettype wire

// >>> dsrp_top_bench.sv
// self-checking bench of the serial register port driven by the host model
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end

module dsrp_top_bench;
  // clock, reset, link
  logic        ref_clk;
  logic        reset;
  logic        ser_clk;
  logic        frame_n;
  logic        host_din;
  logic        wire_lvl;
  logic        dout;
  logic        dout_oe;
  logic        pin;
  logic        pin_oe;
  // sources and register views
  logic [15:0] status;
  logic [15:0] events;
  logic [7:0]  sensor;
  logic [63:0] config_words;
  logic [31:0] sync_words;
  logic        sync_pulse;
  logic [15:0] flags;
  logic        four_wire;
  logic        mode4;
  int          num_errors = 0;
  int          total_checks = 0;
  int          pulses = 0;
  int          cycles = 0;
  int          p0;

  // shared pin: the port wins while it drives, else the host level
  assign wire_lvl = dout_oe ? dout : host_din;

  dsrp_top dut (
    .REF_CLK_IN                 (ref_clk),
    .RESET_IN                   (reset),
    .SERIAL_CLOCK_IN            (ser_clk),
    .SERIAL_FRAME_ENABLE_N_IN   (frame_n),
    .SERIAL_DATA_IN             (wire_lvl),
    .SERIAL_DATA_OUT            (dout),
    .SERIAL_DATA_OE_OUT         (dout_oe),
    .SERIAL_READ_OUT_PIN_OUT    (pin),
    .SERIAL_READ_OUT_PIN_OE_OUT (pin_oe),
    .STATUS_IN                  (status),
    .EVENT_IN                   (events),
    .SENSOR_IN                  (sensor),
    .CONFIG_WORDS_OUT           (config_words),
    .AUTOSYNC_WORDS_OUT         (sync_words),
    .AUTOSYNC_PULSE_OUT         (sync_pulse),
    .EVENT_FLAGS_OUT            (flags),
    .FOUR_WIRE_SELECT_OUT       (four_wire)
  );

  dsrp_host_model host (
    .clk_in      (ref_clk),
    .ser_clk_out (ser_clk),
    .frame_n_out (frame_n),
    .din_out     (host_din),
    .wire_in     (wire_lvl),
    .data_oe_in  (dout_oe),
    .pin_in      (pin),
    .pin_oe_in   (pin_oe)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // pulse count and hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (sync_pulse === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 40000)
    begin
      num_errors++;
      test_done();
    end
  end

  function automatic logic [15:0] pat(input int a);
    return 16'hC3A5 ^ {4{4'(a)}};
  endfunction : pat

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.xfer(1'b0, a, d, 24, 0);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    host.xfer(1'b1, a, 16'h0000, 24, 0);
    `CHECK(host.rd_wire, exp, "read data on shared pin")
    `CHECK(host.rd_pin, mode4 ? exp : 16'hzzzz, "read-out pin")
    `CHECK(host.rd_late, exp, "read bit moved before fall")
    `CHECK({host.tail, host.idle}, {2'b10, mode4, 1'b0, 2'b00}, "tail")
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    reset  = 1'b1;
    status = 16'hA5C3;
    events = 16'h0000;
    sensor = 8'h5A;
    mode4  = 1'b0;
    cyc(10);
    // transmit enable, fifo sync and converter clock sit outside this port
    reset = 1'b0;
    cyc(4);
    `CHECK(config_words, {48'h0000_0000_0000, 16'h44FC}, "config reset")
    `CHECK(four_wire, 1'b0, "wire count after reset")
    `CHECK({sync_pulse, sync_words, flags}, 49'h0, "outputs after reset")
    rd_chk(7'h00, 16'h44FC);
    end_test("reset");
    for (int a = 1; a < 4; a++)
    begin
      wr(7'(a), pat(a));
      rd_chk(7'(a), pat(a));
    end
    `CHECK(config_words[63:16], {pat(3), pat(2), pat(1)}, "words")
    host.xfer(1'b0, 7'h01, 16'hFFFF, 16, 0);
    rd_chk(7'h01, pat(1));
    host.xfer(1'b0, 7'h02, 16'h0F0F, 24, 40);
    rd_chk(7'h02, 16'h0F0F);
    end_test("normal");
    wr(7'h08, 16'h1234);
    rd_chk(7'h08, 16'hA5C3);
    status = 16'h5A3C;
    rd_chk(7'h08, 16'h5A3C);
    wr(7'h0A, 16'hFF3C);
    rd_chk(7'h0A, 16'h5A3C);
    sensor = 8'h81;
    rd_chk(7'h0A, 16'h813C);
    wr(7'h7F, 16'hFFFF);
    rd_chk(7'h7F, 16'h0000);
    end_test("status");
    events = 16'h1008;
    cyc(4);
    events = 16'h0000;
    cyc(4);
    `CHECK(flags, 16'h1008, "event latch")
    rd_chk(7'h09, 16'h1008);
    wr(7'h09, 16'hFFF7);
    `CHECK(flags, 16'h1000, "clear one flag")
    wr(7'h09, 16'h0000);
    `CHECK(flags, 16'h0000, "clear all flags")
    end_test("events");
    p0 = pulses;
    wr(7'h04, 16'h1111);
    `CHECK(pulses - p0, 0, "early sync pulse")
    `CHECK(sync_words, 32'h0000_0000, "early group update")
    wr(7'h05, 16'h2222);
    `CHECK(pulses - p0, 1, "sync pulse count")
    `CHECK(sync_words, 32'h2222_1111, "group words")
    end_test("autosync");
    wr(7'h00, 16'h46FC);
    mode4 = 1'b1;
    `CHECK(four_wire, 1'b1, "four-wire select")
    rd_chk(7'h01, pat(1));
    rd_chk(7'h00, 16'h46FC);
    end_test("four-wire");
    reset = 1'b1;
    cyc(6);
    reset = 1'b0;
    mode4 = 1'b0;
    cyc(4);
    `CHECK(config_words, {48'h0000_0000_0000, 16'h44FC}, "second reset")
    rd_chk(7'h01, 16'h0000);
    end_test("second reset");
    test_done();
  end
endmodule : dsrp_top_bench

`default_nettype wire
